// File: rtl/sadi_pkg.sv
// Purpose: Shared constants and types for the serial converter interface block
// Assumes: 100 MHz system clock; every pin sampled through two flip-flops
// Notes:   Pin-level open-drain outputs travel as output/enable pairs
// Contract
// [RULE1] Trigger rising edge puts track-and-hold into hold and starts a conversion
// [RULE2] Trigger is asynchronous; it is synchronised before use
// [RULE3] Clock pin tied low-rail selects internal oscillator, else external clock
// [RULE4] Frame strobe is active low, open-drain, and frames the result word
// [RULE5] Clock mode 0 V stops and floats serial clock after transfer; -5 V runs
// [RULE6] Outside party must never tie clock mode to the positive supply
// [RULE7] Result bit valid at serial clock falling edge while strobe low
// [RULE8] Receive serial clock is derived from the selected converter clock
// [RULE9] Outside party lowers transmit frame sync first; data expected only after
// [RULE10] Input latch takes a bit on transmit clock falling edge while sync low
// [RULE11] Load strobe falling edge copies input latch into the DAC latch
// [RULE12] External or continuous internal clock: conversion lasts 19 or 20 edges
// [RULE13] Trigger within 30 ns before a rising edge gives 20 edges
// [RULE14] Gated internal clock: every conversion lasts exactly 19 edges
// [RULE15] Result word is 16 bits: two zeros, then 14-bit result, MSB first
// [RULE16] Strobe falls at conversion start; first zero valid on first falling edge
// [RULE17] Result data output changes on each serial clock rising edge
// [RULE18] ADC results and DAC words are two's complement binary
// [RULE19] Outside party holds sync low for a 16-bit word, code in low bits
package sadi_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned DATA_W         = 14;
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned CONV_EDGES     = 19;
  localparam int unsigned ALIGN_NS       = 30;
  localparam int unsigned ALIGN_CYC      = (ALIGN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC_PERIOD_NS  = 500;
  localparam int unsigned OSC_HALF_CYC   = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned CNT_W          = 8;
  localparam int unsigned NUM_PINS       = 8;

  // Index of each pin in the synchroniser vector
  localparam int unsigned PIN_TRIG       = 0;
  localparam int unsigned PIN_EXT_CLK    = 1;
  localparam int unsigned PIN_INT_SEL    = 2;
  localparam int unsigned PIN_CONT       = 3;
  localparam int unsigned PIN_TFS        = 4;
  localparam int unsigned PIN_TRANSMIT_SERIAL_CLOCK       = 5;
  localparam int unsigned PIN_TDATA      = 6;
  localparam int unsigned PIN_LOAD       = 7;

  typedef struct packed {
    logic o;
    logic oe;
  } sadi_od_pin_s;

  typedef enum logic [0:0] {
    SADI_IDLE,
    SADI_CONV
  } sadi_state_e;

endpackage : sadi_pkg

// File: rtl/sadi_sync.sv
// Purpose: Two-flop synchroniser with edge detection for a group of pins
// Assumes: Inputs are asynchronous to clk_i
// Notes:   Edges come from the second and third flops only
`timescale 1ns/10ps
module sadi_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // Only sync_q reads meta_q, keeping metastability off the logic
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge flags are one-cycle pulses
  always_comb
  begin
    level_o = sync_q;
    rise_o  = sync_q & ~prev_q;
    fall_o  = ~sync_q & prev_q;
  end

endmodule : sadi_sync

// File: rtl/sadi_top.sv
// Purpose: Conversion control, result serialiser and DAC serial input
// Assumes: Converter core delivers its result on adc_result_i at start
// Notes:   Open-drain pins only ever pull low; enable high means pulling
`timescale 1ns/10ps
module sadi_top #(
  parameter int unsigned DATA_W   = sadi_pkg::DATA_W,
  parameter int unsigned OSC_HALF = sadi_pkg::OSC_HALF_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  conversion_trigger_i,
  input  wire logic                  adc_clock_i,
  input  wire logic                  clock_pin_at_low_rail_i,
  input  wire logic                  clock_mode_continuous_i,
  input  wire logic                  transmit_frame_sync_i,
  input  wire logic                  transmit_serial_clock_i,
  input  wire logic                  transmit_serial_input_i,
  input  wire logic                  dac_load_strobe_i,
  input  wire logic [DATA_W-1:0]     adc_result_i,
  output sadi_pkg::sadi_od_pin_s     receive_frame_strobe_o,
  output sadi_pkg::sadi_od_pin_s     receive_serial_clock_o,
  output sadi_pkg::sadi_od_pin_s     receive_serial_output_o,
  output logic                       track_hold_o,
  output logic                       conv_busy_o,
  output logic [DATA_W-1:0]          dac_latch_o
);

  localparam int unsigned CW = sadi_pkg::CNT_W;
  localparam int unsigned WW = sadi_pkg::WORD_W;
  localparam logic [CW-1:0] EDGES_C = CW'(sadi_pkg::CONV_EDGES);
  localparam logic [CW-1:0] ALIGN_C = CW'(sadi_pkg::ALIGN_CYC);
  localparam logic [CW-1:0] HALF_C  = CW'(OSC_HALF);
  localparam logic [CW-1:0] WORD_C  = CW'(WW);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [sadi_pkg::NUM_PINS-1:0] pin_async;
  logic [sadi_pkg::NUM_PINS-1:0] pin_lvl;
  logic [sadi_pkg::NUM_PINS-1:0] pin_rise;
  logic [sadi_pkg::NUM_PINS-1:0] pin_fall;

  // All pins share one synchroniser instance
  always_comb
  begin
    pin_async                        = '0;
    pin_async[sadi_pkg::PIN_TRIG]    = conversion_trigger_i;
    pin_async[sadi_pkg::PIN_EXT_CLK] = adc_clock_i;
    pin_async[sadi_pkg::PIN_INT_SEL] = clock_pin_at_low_rail_i;
    pin_async[sadi_pkg::PIN_CONT]    = clock_mode_continuous_i;
    pin_async[sadi_pkg::PIN_TFS]     = transmit_frame_sync_i;
    pin_async[sadi_pkg::PIN_TRANSMIT_SERIAL_CLOCK]    = transmit_serial_clock_i;
    pin_async[sadi_pkg::PIN_TDATA]   = transmit_serial_input_i;
    pin_async[sadi_pkg::PIN_LOAD]    = dac_load_strobe_i;
  end

  sadi_sync #(
    .W (sadi_pkg::NUM_PINS)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (pin_async),
    .level_o  (pin_lvl),
    .rise_o   (pin_rise),
    .fall_o   (pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock source and conversion control

  sadi_pkg::sadi_state_e state_q, state_d;
  logic [CW-1:0]         osc_cnt_q, osc_cnt_d;
  logic                  osc_lvl_q, osc_lvl_d;
  logic                  sel_prev_q, sel_prev_d;
  logic [CW-1:0]         edge_cnt_q, edge_cnt_d;
  logic [CW-1:0]         since_q, since_d;
  logic                  first_q, first_d;
  logic                  use_int;
  logic                  gated;
  logic                  start;
  logic                  sel_lvl;
  logic                  sel_rise;
  logic                  sel_fall;

  // Next state of oscillator, edge counter and conversion state
  always_comb
  begin
    use_int    = pin_lvl[sadi_pkg::PIN_INT_SEL];                      // [RULE3]
    gated      = use_int & ~pin_lvl[sadi_pkg::PIN_CONT];
    start      = pin_rise[sadi_pkg::PIN_TRIG] & (state_q == sadi_pkg::SADI_IDLE); // [RULE1] [RULE2]
    state_d    = state_q;
    edge_cnt_d = edge_cnt_q;
    first_d    = first_q;
    since_d    = (since_q == {CW{1'b1}}) ? since_q : since_q + 1'b1;
    osc_cnt_d  = osc_cnt_q;
    osc_lvl_d  = osc_lvl_q;
    // Gated oscillator restarts at the trigger so its phase is fixed
    if (gated && (start || state_q == sadi_pkg::SADI_IDLE))
    begin
      osc_cnt_d = '0;
      osc_lvl_d = 1'b0;
    end
    else if (osc_cnt_q == HALF_C - 1'b1)
    begin
      osc_cnt_d = '0;
      osc_lvl_d = ~osc_lvl_q;
    end
    else
    begin
      osc_cnt_d = osc_cnt_q + 1'b1;
    end
    sel_lvl    = use_int ? osc_lvl_q : pin_lvl[sadi_pkg::PIN_EXT_CLK];  // [RULE8]
    sel_prev_d = sel_lvl;
    sel_rise   = sel_lvl & ~sel_prev_q;
    sel_fall   = ~sel_lvl & sel_prev_q;
    case (state_q)
      sadi_pkg::SADI_IDLE:
      begin
        if (start)
        begin
          state_d    = sadi_pkg::SADI_CONV;
          edge_cnt_d = '0;
          since_d    = '0;
          first_d    = 1'b1;
        end
      end
      sadi_pkg::SADI_CONV:
      begin
        if (sel_rise)
        begin
          first_d = 1'b0;
          // A too-close first edge is not counted: one extra edge
          if (!(first_q && !gated && since_q < ALIGN_C))               // [RULE12] [RULE13] [RULE14]
          begin
            edge_cnt_d = edge_cnt_q + 1'b1;
            if (edge_cnt_q == EDGES_C - 1'b1)
            begin
              state_d = sadi_pkg::SADI_IDLE;
            end
          end
        end
      end
      default:
      begin
        state_d = sadi_pkg::SADI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q    <= sadi_pkg::SADI_IDLE;
      osc_cnt_q  <= '0;
      osc_lvl_q  <= 1'b0;
      sel_prev_q <= 1'b0;
      edge_cnt_q <= '0;
      since_q    <= '0;
      first_q    <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      osc_cnt_q  <= osc_cnt_d;
      osc_lvl_q  <= osc_lvl_d;
      sel_prev_q <= sel_prev_d;
      edge_cnt_q <= edge_cnt_d;
      since_q    <= since_d;
      first_q    <= first_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result serialiser and open-drain pins

  logic [WW-1:0] shift_q, shift_d;
  logic [CW-1:0] fall_cnt_q, fall_cnt_d;
  logic          frame_q, frame_d;
  sadi_pkg::sadi_od_pin_s rfs_q, rfs_d, rclk_q, rclk_d, rdat_q, rdat_d;
  logic          hold_d;

  // Word loads at start; shifts on rising edges after the first fall
  always_comb
  begin
    shift_d    = shift_q;
    fall_cnt_d = fall_cnt_q;
    frame_d    = frame_q;
    if (start)
    begin
      frame_d    = 1'b1;                                               // [RULE16]
      shift_d    = {{(WW - DATA_W){1'b0}}, adc_result_i};              // [RULE15] [RULE18]
      // A fall in the start cycle reaches the pin one cycle late, so count it now
      fall_cnt_d = {{(CW - 1){1'b0}}, sel_fall};
    end
    else if (frame_q)
    begin
      if (sel_fall)
      begin
        fall_cnt_d = fall_cnt_q + 1'b1;
      end
      if (sel_rise && fall_cnt_q != '0)
      begin
        if (fall_cnt_q == WORD_C)
        begin
          frame_d = 1'b0;
        end
        else
        begin
          shift_d = {shift_q[WW-2:0], 1'b0};                           // [RULE17]
        end
      end
    end
    hold_d    = (state_d == sadi_pkg::SADI_CONV);                      // [RULE1]
    rfs_d.o   = 1'b0;
    rfs_d.oe  = frame_d;                                               // [RULE4]
    rdat_d.o  = 1'b0;
    rdat_d.oe = frame_d & ~shift_d[WW-1];                              // [RULE7]
    rclk_d.o  = 1'b0;
    // Gated mode drives the clock from the first counted fall to the end of the word;
    // the start cycle holds the pin so no clock fall lands on the strobe edge
    if (start)
    begin
      rclk_d.oe = rclk_q.oe;
    end
    else
    begin
      rclk_d.oe = (pin_lvl[sadi_pkg::PIN_CONT] | (frame_d & (fall_cnt_d != '0)))
                  & ~sel_lvl;                                          // [RULE5] [RULE8]
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      shift_q      <= '0;
      fall_cnt_q   <= '0;
      frame_q      <= 1'b0;
      rfs_q        <= '0;
      rclk_q       <= '0;
      rdat_q       <= '0;
      track_hold_o <= 1'b0;
      conv_busy_o  <= 1'b0;
    end
    else
    begin
      shift_q      <= shift_d;
      fall_cnt_q   <= fall_cnt_d;
      frame_q      <= frame_d;
      rfs_q        <= rfs_d;
      rclk_q       <= rclk_d;
      rdat_q       <= rdat_d;
      track_hold_o <= hold_d;
      conv_busy_o  <= hold_d;
    end
  end

  assign receive_frame_strobe_o  = rfs_q;
  assign receive_serial_clock_o  = rclk_q;
  assign receive_serial_output_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // DAC serial input latch and load

  logic [WW-1:0]     in_latch_q, in_latch_d;
  logic [DATA_W-1:0] dac_d;

  // Bits enter only while sync is low; the low bits form the code
  always_comb
  begin
    in_latch_d = in_latch_q;
    dac_d      = dac_latch_o;
    if (pin_fall[sadi_pkg::PIN_TRANSMIT_SERIAL_CLOCK] && !pin_lvl[sadi_pkg::PIN_TFS])   // [RULE9] [RULE10]
    begin
      in_latch_d = {in_latch_q[WW-2:0], pin_lvl[sadi_pkg::PIN_TDATA]}; // [RULE19]
    end
    if (pin_fall[sadi_pkg::PIN_LOAD])
    begin
      dac_d = in_latch_q[DATA_W-1:0];                                  // [RULE11] [RULE18]
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      in_latch_q  <= '0;
      dac_latch_o <= '0;
    end
    else
    begin
      in_latch_q  <= in_latch_d;
      dac_latch_o <= dac_d;
    end
  end

endmodule : sadi_top

// File: verification/sadi_checker.sv
// Purpose: Port-level assertions for sadi_top
// Assumes: Open-drain wire level is the inverse of each enable
// Notes:   Windows include the two-flop lag of the pins
`timescale 1ns/10ps
module sadi_checker #(
  parameter int unsigned DATA_W = 14
) (
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  input wire logic                   conversion_trigger_i,
  input wire logic                   clock_mode_continuous_i,
  input wire logic                   dac_load_strobe_i,
  input wire sadi_pkg::sadi_od_pin_s receive_frame_strobe_o,
  input wire sadi_pkg::sadi_od_pin_s receive_serial_clock_o,
  input wire sadi_pkg::sadi_od_pin_s receive_serial_output_o,
  input wire logic                   track_hold_o,
  input wire logic                   conv_busy_o,
  input wire logic [DATA_W-1:0]      dac_latch_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  //////////////////////////////////////////////////////////////
  // Serial clock falls per frame, and cycles since the last load fall
  logic       pc_q, pc_d, lp_q, lp_d;
  logic [4:0] fb_q, fb_d;
  logic [3:0] ld_q, ld_d;
  always_comb
  begin
    pc_d = receive_serial_clock_o.oe;
    lp_d = dac_load_strobe_i;
    fb_d = receive_frame_strobe_o.oe ? fb_q + 5'(~pc_q & pc_d) : 5'h00;
    ld_d = (lp_q & ~lp_d) ? 4'h0 : ld_q + 4'(ld_q != 4'hf);
  end
  // Age saturates, so a latch change long after any load still fails
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      {pc_q, lp_q, fb_q, ld_q} <= {2'b00, 5'h00, 4'hf};
    else
      {pc_q, lp_q, fb_q, ld_q} <= {pc_d, lp_d, fb_d, ld_d};
  end
  sequence s_trig; $rose(conversion_trigger_i) && !conv_busy_o; endsequence
  sequence s_hold; ##[2:6] $rose(track_hold_o); endsequence
  property p_start; s_trig |-> s_hold; endproperty
  property p_busy;
    conv_busy_o == track_hold_o && !($fell(conv_busy_o) && receive_frame_strobe_o.oe);
  endproperty
  property p_od;
    {receive_frame_strobe_o.o, receive_serial_clock_o.o, receive_serial_output_o.o} == 3'b000;
  endproperty
  property p_frame; $rose(track_hold_o) |-> $rose(receive_frame_strobe_o.oe); endproperty
  property p_zero; $rose(receive_frame_strobe_o.oe) |-> receive_serial_output_o.oe; endproperty
  property p_gated;
    (!clock_mode_continuous_i && !receive_frame_strobe_o.oe) [*5] |-> !receive_serial_clock_o.oe;
  endproperty
  property p_bits; $fell(receive_frame_strobe_o.oe) |-> fb_q == 5'h10; endproperty
  property p_dac; $changed(dac_latch_o) |-> ld_q <= 4'h6; endproperty
  a_start: assert property (p_start) else $error("hold missed trigger");
  a_busy: assert property (p_busy) else $error("busy differs from hold or frame");
  a_od: assert property (p_od) else $error("open-drain pin drove high");
  a_frame: assert property (p_frame) else $error("strobe not at start");
  a_zero: assert property (p_zero) else $error("first bit not zero");
  a_gated: assert property (p_gated) else $error("gated clock still driven");
  a_bits: assert property (p_bits) else $error("frame bit count wrong");
  a_dac: assert property (p_dac) else $error("latch moved without load");
endmodule : sadi_checker

bind sadi_top sadi_checker #(.DATA_W(DATA_W)) i_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .conversion_trigger_i(conversion_trigger_i),
  .clock_mode_continuous_i(clock_mode_continuous_i), .dac_load_strobe_i(dac_load_strobe_i),
  .receive_frame_strobe_o(receive_frame_strobe_o),
  .receive_serial_clock_o(receive_serial_clock_o),
  .receive_serial_output_o(receive_serial_output_o), .track_hold_o(track_hold_o),
  .conv_busy_o(conv_busy_o), .dac_latch_o(dac_latch_o)
);

// File: verification/sadi_host_model.sv
// Purpose: Host serial port that reads results and writes DAC words
// Assumes: Pin levels arrive resolved through the pull-ups
// Notes:   Transmit clock has a 160 ns period and idles high
`timescale 1ns/10ps
module sadi_host_model (
  input  wire logic clk_i,
  input  wire logic fr_w_i,
  input  wire logic ck_w_i,
  input  wire logic dq_w_i,
  output logic      sync_o,
  output logic      sclk_o,
  output logic      sdat_o
);
  logic [15:0] rx_q = 16'h0000;
  int          rx_n = 0;
  int          frames = 0;
  initial
  begin
    sync_o = 1'b1;
    sclk_o = 1'b1;
    sdat_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////
  // A new frame restarts the bit count
  always @(negedge fr_w_i)
  begin
    rx_n = 0;
    frames++;
  end
  // Bits are taken on the falling clock only while framed
  always @(negedge ck_w_i)
    if (!fr_w_i)
    begin
      rx_q = {rx_q[14:0], dq_w_i};
      rx_n++;
    end
  // Sync falls first and stays low for all 16 bits, code in the low bits
  task automatic send_word(input logic [15:0] w);
    sync_o = 1'b0;
    repeat (8) @(negedge clk_i);
    for (int i = 15; i >= 0; i--)
    begin
      sdat_o = w[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
      repeat (8) @(negedge clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
    end
    sync_o = 1'b1;
    sdat_o = ~w[0];
  endtask : send_word
endmodule : sadi_host_model

// File: verification/sadi_top_tb.sv
// Purpose: Self-checking bench for sadi_top
// Assumes: Pull-ups on open-drain pins; oscillator half period cut to 4
// Notes:   Row table first, then retrigger and mid-conversion reset
`timescale 1ns/10ps
module sadi_top_tb;
  localparam int unsigned OSC_HALF = 4;
  typedef struct packed {
    logic        io;
    logic        ct;
    logic [13:0] res;
    logic [15:0] dac;
  } sadi_row_s;
  // Every clock source and mode, with end codes of both paths
  sadi_row_s rows [4] = '{'{1'b0, 1'b0, 14'h1fff, 16'h2000}, '{1'b0, 1'b1, 14'h2000, 16'h1fff},
                         '{1'b1, 1'b0, 14'h3fff, 16'h0001}, '{1'b1, 1'b1, 14'h0001, 16'h3fff}};
  logic                   clk_i = 1'b0, resetn_i = 1'b0, trig = 1'b0, aclk = 1'b0;
  logic                   int_sel = 1'b0, cont = 1'b0, load = 1'b1;
  logic [13:0]            res = 14'h0000;
  logic                   sync, sclk, sdat, hold, busy;
  logic [13:0]            latch;
  sadi_pkg::sadi_od_pin_s fs, ck, dq;
  int                     n_fail = 0, n_checks = 0;
  initial
    forever #5 clk_i = ~clk_i;
  // Converter clock offset so its edges never coincide with clk_i edges
  initial
  begin
    #3;
    forever #80 aclk = ~aclk;
  end
  sadi_top #(.OSC_HALF(OSC_HALF)) i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .conversion_trigger_i(trig), .adc_clock_i(aclk),
    .clock_pin_at_low_rail_i(int_sel), .clock_mode_continuous_i(cont),
    .transmit_frame_sync_i(sync), .transmit_serial_clock_i(sclk),
    .transmit_serial_input_i(sdat), .dac_load_strobe_i(load), .adc_result_i(res),
    .receive_frame_strobe_o(fs), .receive_serial_clock_o(ck), .receive_serial_output_o(dq),
    .track_hold_o(hold), .conv_busy_o(busy), .dac_latch_o(latch)
  );
  sadi_host_model i_host (
    .clk_i(clk_i), .fr_w_i(!fs.oe), .ck_w_i(!ck.oe), .dq_w_i(!dq.oe),
    .sync_o(sync), .sclk_o(sclk), .sdat_o(sdat)
  );
  //////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic late();
    n_fail++;
    $display("ERROR t=%0t wait ran out", $time);
    complete_run();
  endtask : late
  // One conversion; rt pulses the trigger again while busy
  task automatic convert(input bit rt, output int nb);
    int k;
    nb = 0;
    trig = 1'b1;
    for (k = 0; k < 20 && busy !== 1'b1; k++)
      @(negedge clk_i);
    if (k == 20)
      late();
    repeat (6) @(negedge clk_i);
    trig = 1'b0;
    for (k = 0; k < 2000 && busy !== 1'b0; k++)
    begin
      @(negedge clk_i);
      nb++;
      trig = rt && (k inside {[100:110]});
    end
    if (k == 2000)
      late();
  endtask : convert
  initial
  begin
    int nb, per, hi, tg, f0;
    logic pk;
    logic [15:0] prev;
    prev = 16'h0000;
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (5) @(negedge clk_i);
    for (int i = 0; i < 4; i++)
    begin
      int_sel = rows[i].io;
      cont = rows[i].ct;
      res = rows[i].res;
      repeat (20) @(negedge clk_i);
      convert(1'b0, nb);
      chk(i_host.rx_q, {2'b00, res});
      chk(16'(i_host.rx_n), 16'h0010);
      per = int_sel ? 2 * OSC_HALF : 16;
      hi = ((int_sel && !cont) ? 19 : 20) * per + 3;
      chk(16'(nb + 6 >= 18 * per && nb + 6 <= hi), 16'h0001);
      tg = 0;
      pk = ck.oe;
      repeat (64)
      begin
        @(negedge clk_i);
        tg += int'(ck.oe !== pk);
        pk = ck.oe;
      end
      chk(16'(cont ? (tg >= 128 / per - 1 && tg <= 128 / per + 1) : tg == 0),
          16'h0001);
      i_host.send_word(rows[i].dac);
      chk({2'b00, latch}, prev);
      load = 1'b0;
      repeat (5) @(negedge clk_i);
      load = 1'b1;
      prev = {2'b00, rows[i].dac[13:0]};
      chk({2'b00, latch}, prev);
    end
    // A trigger while converting must start nothing
    f0 = i_host.frames;
    convert(1'b1, nb);
    repeat (40) @(negedge clk_i);
    chk(16'(i_host.frames - f0), 16'h0001);
    chk({15'h0000, busy}, 16'h0000);
    // Reset mid-conversion clears all outputs, then a fresh word runs
    trig = 1'b1;
    repeat (40) @(negedge clk_i);
    resetn_i = 1'b0;
    @(negedge clk_i);
    chk({fs.oe, ck.oe, dq.oe, hold, busy, 11'h000}, 16'h0000);
    chk({2'b00, latch}, 16'h0000);
    trig = 1'b0;
    res = 14'h2aaa;
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (5) @(negedge clk_i);
    convert(1'b0, nb);
    chk(i_host.rx_q, {2'b00, res});
    complete_run();
  end
endmodule : sadi_top_tb
